// ===== hw/gyro_host_ctrl.sv
/*
 Host controller that drives a gyroscope register port over I2C or SPI, plus its
 two-flop synchroniser and the two-entry read buffer.
 Assumes external pull-ups on SDA and SCL and a slave on the SPI pins with its own chip select.
*/
`timescale 1ns/1ns
// two-flop synchroniser for a pin input
module pin_sync2 (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_d,
	output logic o_q
);
	logic meta_r;
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			meta_r <= 1'h1;
			o_q <= 1'h1;
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule

// small shift buffer, head entry always at index zero
module byte_skid_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem_r [DEPTH];
	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;
	logic push;
	logic pop;
	logic [CW-1:0] widx;
	assign o_in_ready = count_r < CW'(DEPTH);
	assign pop = o_out_valid && i_out_ready;
	assign push = i_in_valid && o_in_ready;
	assign widx = count_r - CW'(pop);
	assign count_nxt = count_r + CW'(push) - CW'(pop);
	assign o_out_data = mem_r[0];
	// occupancy and registered valid
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			count_r <= '0;
			o_out_valid <= 1'h0;
		end else begin
			count_r <= count_nxt;
			o_out_valid <= count_nxt != '0;
		end
	end
	// storage: shift on pop, write behind the last kept entry
	always_ff @(posedge i_core_clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (push && widx == CW'(i)) begin
				mem_r[i] <= i_in_data;
			end else if (pop && i < DEPTH - 1) begin
				mem_r[i] <= mem_r[i+1];
			end
		end
	end
endmodule

module gyro_host_ctrl
	import gyro_link_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic i_cmd_spi,
	input wire logic i_cmd_read,
	input wire logic [7:0] i_cmd_reg,
	input wire logic [7:0] i_cmd_len,
	input wire logic i_address_select_pin,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [7:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [7:0] o_rd_data,
	output logic o_busy,
	output logic o_done,
	output logic o_ack_err,
	input wire logic i_scl,
	output logic o_scl_out,
	output logic o_scl_oe,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi,
	input wire logic i_miso
);
	state_t state_r;
	seg_t seg_r;
	logic spi_r, rd_r, addr_sel_r, nack_r, push_r, buf_ready;
	logic [7:0] reg_r, cnt_r, shreg_r, qcnt_r, qtr_len;
	logic [3:0] bit_r, last_bit;
	logic [1:0] q_r;
	logic scl_s, sda_s, miso_s, stretch, tick, timed, rx;

	pin_sync2 u_scl (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_scl), .o_q(scl_s));
	pin_sync2 u_sda (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_sda), .o_q(sda_s));
	pin_sync2 u_miso (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_d(i_miso), .o_q(miso_s));

	byte_skid_buf #(.W(BYTE_W), .DEPTH(RD_BUF_DEPTH)) u_rdbuf (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_in_valid(push_r),
		.o_in_ready(buf_ready),
		.i_in_data(shreg_r),
		.o_out_valid(o_rd_valid),
		.i_out_ready(i_rd_ready),
		.o_out_data(o_rd_data)
	);

	// quarter-period timer; a slave holding SCL low freezes it
	assign qtr_len = spi_r ? QTR_SPI : QTR_I2C;
	assign stretch = !spi_r && !o_scl_oe && !scl_s;
	assign timed = state_r == S_START || state_r == S_BIT || state_r == S_STOP;
	assign tick = timed && !stretch && qcnt_r == qtr_len - 8'h01;
	assign rx = rd_r && seg_r == SEG_DATA;
	assign last_bit = spi_r ? SPI_LAST_BIT : I2C_ACK_BIT;
	assign o_scl_out = 1'h0;
	assign o_sda_out = 1'h0;

	always_ff @(posedge i_core_clk) begin
		if (i_rst || !timed || tick) begin
			qcnt_r <= 8'h00;
		end else if (!stretch) begin
			qcnt_r <= qcnt_r + 8'h01;
		end
	end

	// transfer sequencer and pin drive
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_r <= S_IDLE;
			seg_r <= SEG_ADDR;
			{spi_r, rd_r, addr_sel_r, nack_r, push_r} <= '0;
			{reg_r, cnt_r, shreg_r} <= '0;
			bit_r <= 4'h0;
			q_r <= Q_DRIVE;
			{o_cmd_ready, o_wr_ready, o_busy, o_done, o_ack_err} <= '0;
			{o_scl_oe, o_sda_oe, o_sclk, o_mosi} <= '0;
			o_cs_n <= 1'h1;
		end else begin
			push_r <= 1'h0;
			o_done <= 1'h0;
			if (tick) begin
				q_r <= q_r + 2'h1;
			end
			case (state_r)
			S_IDLE: begin
				q_r <= Q_DRIVE;
				o_cmd_ready <= 1'h1;
				if (o_cmd_ready && i_cmd_valid) begin
					o_cmd_ready <= 1'h0;
					o_busy <= 1'h1;
					o_ack_err <= 1'h0;
					nack_r <= 1'h0;
					spi_r <= i_cmd_spi;
					rd_r <= i_cmd_read;
					reg_r <= i_cmd_reg;
					cnt_r <= i_cmd_len;
					addr_sel_r <= i_address_select_pin;
					seg_r <= i_cmd_spi ? SEG_REG : SEG_ADDR;
					state_r <= S_START;
				end
			end
			S_START: if (tick) begin
				case (q_r)
				Q_DRIVE: begin
					o_sda_oe <= 1'h0;
					o_cs_n <= !spi_r;
				end
				Q_RISE: o_scl_oe <= 1'h0;
				Q_SAMPLE: o_sda_oe <= !spi_r;
				default: begin
					o_scl_oe <= !spi_r;
					state_r <= S_LOAD;
				end
				endcase
			end
			S_LOAD: begin
				q_r <= Q_DRIVE;
				bit_r <= 4'h0;
				case (seg_r)
				SEG_ADDR: begin
					shreg_r <= {I2C_ADDR_FIXED, addr_sel_r, I2C_DIR_WRITE};
					state_r <= S_BIT;
				end
				SEG_RADDR: begin
					shreg_r <= {I2C_ADDR_FIXED, addr_sel_r, I2C_DIR_READ};
					state_r <= S_BIT;
				end
				SEG_REG: begin
					shreg_r <= spi_r ? {rd_r ? SPI_DIR_READ : SPI_DIR_WRITE, reg_r[6:0]} : reg_r;
					state_r <= S_BIT;
				end
				default: begin
					if (rd_r) begin
						// room for this byte, checked once the last one has finished entering
						if (buf_ready && !push_r) begin
							shreg_r <= RX_IDLE_BYTE;
							state_r <= S_BIT;
						end
					end else if (o_wr_ready && i_wr_valid) begin
						o_wr_ready <= 1'h0;
						shreg_r <= i_wr_data;
						state_r <= S_BIT;
					end else begin
						o_wr_ready <= 1'h1;
					end
				end
				endcase
			end
			S_BIT: if (tick) begin
				case (q_r)
				Q_DRIVE: begin
					if (spi_r) begin
						o_mosi <= !rx && shreg_r[7];
					end else if (bit_r == I2C_ACK_BIT) begin
						o_sda_oe <= rx && cnt_r != 8'h00;
					end else begin
						o_sda_oe <= !rx && !shreg_r[7];
					end
				end
				Q_RISE: begin
					o_scl_oe <= 1'h0;
					o_sclk <= spi_r;
				end
				Q_SAMPLE: begin
					if (!spi_r && bit_r == I2C_ACK_BIT) begin
						nack_r <= !rx && sda_s;
					end else begin
						shreg_r <= {shreg_r[6:0], spi_r ? miso_s : sda_s};
					end
				end
				default: begin
					o_scl_oe <= !spi_r;
					o_sclk <= 1'h0;
					bit_r <= bit_r + 4'h1;
					if (bit_r == last_bit) begin
						push_r <= rx;
						state_r <= S_LOAD;
						case (seg_r)
						SEG_ADDR: seg_r <= SEG_REG;
						SEG_REG: begin
							seg_r <= (rd_r && !spi_r) ? SEG_RADDR : SEG_DATA;
							if (rd_r && !spi_r) begin
								state_r <= S_START;
							end
						end
						SEG_RADDR: seg_r <= SEG_DATA;
						default: begin
							if (cnt_r == 8'h00) begin
								state_r <= S_STOP;
							end else begin
								cnt_r <= cnt_r - 8'h01;
							end
						end
						endcase
						if (nack_r) begin
							o_ack_err <= 1'h1;
							push_r <= 1'h0;
							state_r <= S_STOP;
						end
					end
				end
				endcase
			end
			S_STOP: if (tick) begin
				case (q_r)
				Q_DRIVE: o_sda_oe <= !spi_r;
				Q_RISE: o_scl_oe <= 1'h0;
				Q_SAMPLE: begin
					o_sda_oe <= 1'h0;
					o_cs_n <= 1'h1;
				end
				default: begin
					o_busy <= 1'h0;
					o_done <= 1'h1;
					state_r <= S_IDLE;
				end
				endcase
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	// checks on the link pins and the sequencer
	chk_cs_idle_high: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state_r == S_IDLE |-> o_cs_n) else $error("chip select low while idle");
	chk_sda_fall_start: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!o_scl_oe && $rose(o_sda_oe)) |-> state_r == S_START)
		else $error("sda fell with scl high outside start");
	chk_sda_rise_stop: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!spi_r && !o_scl_oe && $fell(o_sda_oe)) |-> state_r == S_STOP)
		else $error("sda rose with scl high outside stop");
	chk_ack_slot_free: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!spi_r && state_r == S_BIT && bit_r == I2C_ACK_BIT && !rx && q_r == Q_RISE)
		|-> !o_sda_oe) else $error("host drives sda in slave ack slot");
	chk_read_ack_nack: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!spi_r && state_r == S_BIT && bit_r == I2C_ACK_BIT && rx && q_r == Q_SAMPLE)
		|-> o_sda_oe == (cnt_r != 8'h00)) else $error("wrong ack on read byte");
	chk_dev_addr_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_r == S_LOAD && seg_r == SEG_ADDR)
		|=> shreg_r == {I2C_ADDR_FIXED, addr_sel_r, I2C_DIR_WRITE})
		else $error("bad slave address byte");
	chk_read_dir_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state_r == S_LOAD && seg_r == SEG_RADDR) |=> shreg_r[0] == I2C_DIR_READ)
		else $error("read address lacks read bit");
	chk_mosi_on_fall: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$changed(o_mosi) |-> !o_sclk) else $error("mosi moved with sclk high");
	chk_msb_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(spi_r && !rx && state_r == S_BIT && q_r == Q_RISE && !tick)
		|-> o_mosi == shreg_r[7]) else $error("mosi not msb of shift register");
	chk_sclk_high_time: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_sclk) |-> o_sclk [*8]) else $error("sclk high phase too short");
	chk_spi_two_bytes: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(spi_r && state_r == S_STOP) |-> seg_r == SEG_DATA)
		else $error("spi frame ended before a data byte");
	chk_burst_next: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(tick && state_r == S_BIT && q_r == Q_FALL && bit_r == last_bit
		&& seg_r == SEG_DATA && cnt_r != 8'h00 && !nack_r)
		|=> state_r == S_LOAD && seg_r == SEG_DATA) else $error("burst did not continue");
endmodule

// ===== hw/gyro_link_pkg.sv
/*
 Constants and types for the host side serial register controller.
 Assumes a 100 MHz core clock and one gyroscope slave reached over I2C or 4-wire SPI.
*/
package gyro_link_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SPI_SCLK_PERIOD_NS = 1000;
	localparam int I2C_SCL_PERIOD_NS = 2500;
	// quarter of a link clock period, rounded up so the rate is never exceeded
	localparam logic [7:0] QTR_SPI = 8'((SPI_SCLK_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
		/ (4 * CLK_PERIOD_NS));
	localparam logic [7:0] QTR_I2C = 8'((I2C_SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
		/ (4 * CLK_PERIOD_NS));
	localparam logic [5:0] I2C_ADDR_FIXED = 6'h34;
	localparam logic I2C_DIR_WRITE = 1'h0;
	localparam logic I2C_DIR_READ = 1'h1;
	localparam logic SPI_DIR_READ = 1'h1;
	localparam logic SPI_DIR_WRITE = 1'h0;
	localparam logic [3:0] I2C_ACK_BIT = 4'h8;
	localparam logic [3:0] SPI_LAST_BIT = 4'h7;
	localparam logic [1:0] Q_DRIVE = 2'h0;
	localparam logic [1:0] Q_RISE = 2'h1;
	localparam logic [1:0] Q_SAMPLE = 2'h2;
	localparam logic [1:0] Q_FALL = 2'h3;
	localparam logic [7:0] RX_IDLE_BYTE = 8'hFF;
	localparam int BYTE_W = 8;
	localparam int RD_BUF_DEPTH = 2;
	typedef enum logic [2:0] {S_IDLE, S_START, S_LOAD, S_BIT, S_STOP} state_t;
	typedef enum logic [1:0] {SEG_ADDR, SEG_REG, SEG_RADDR, SEG_DATA} seg_t;
endpackage

// ===== verification/gyro_slave_model.sv
/*
 Behavioural gyroscope register slave answering on I2C and on 4-wire SPI.
 Assumes the bench resolves the open-drain wires with pull-ups and drives select and pacing.
*/
`timescale 1ns/1ns
module gyro_slave_model
	import gyro_link_pkg::*;
(
	input wire logic i_sel,
	input wire logic i_slow,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_oe,
	output logic o_sda_oe,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso
);
	logic [7:0] regs [0:255];
	logic [7:0] ptr;
	logic [7:0] ssh;
	logic srd;
	int scnt;
	// one byte in; brk 1 marks a repeated start, 2 a stop
	task automatic rx_byte(output logic [7:0] b, output int brk);
		brk = 0;
		for (int k = 0; k < 8 && brk == 0; k++) begin
			@(posedge i_scl);
			b = {b[6:0], i_sda};
			@(negedge i_scl or i_sda);
			if (i_scl) brk = i_sda ? 2 : 1;
		end
	endtask
	// ninth clock low, slow mode stretches scl first
	task automatic ack();
		o_sda_oe = 1'b1;
		if (i_slow) begin
			o_scl_oe = 1'b1;
			#3000;
			o_scl_oe = 1'b0;
		end
		@(posedge i_scl);
		@(negedge i_scl);
		o_sda_oe = 1'b0;
	endtask
	// one byte out msb first, then the host's acknowledge
	task automatic tx_byte(input logic [7:0] d, output logic mack);
		for (int k = 7; k >= 0; k--) begin
			o_sda_oe = ~d[k];
			@(posedge i_scl);
			@(negedge i_scl);
		end
		o_sda_oe = 1'b0;
		@(posedge i_scl);
		mack = ~i_sda;
		@(negedge i_scl);
	endtask
	task automatic i2c_frame();
		logic [7:0] b;
		int brk;
		logic mack;
		forever begin
			rx_byte(b, brk);
			if (brk != 0 || b[7:1] !== {I2C_ADDR_FIXED, i_sel}) return;
			ack();
			if (b[0] == I2C_DIR_READ) begin
				mack = 1'b1;
				while (mack) begin
					tx_byte(regs[ptr], mack);
					ptr++;
				end
				return;
			end
			rx_byte(b, brk);
			if (brk == 2) return;
			if (brk == 1) continue;
			ptr = b;
			ack();
			while (brk == 0) begin
				rx_byte(b, brk);
				if (brk == 0) begin
					regs[ptr] = b;
					ptr++;
					ack();
				end
			end
			if (brk == 2) return;
		end
	endtask
	// known register pattern, lines released, then wait for each start
	initial begin
		for (int i = 0; i < 256; i++) regs[i] = 8'(~i);
		o_sda_oe = 1'b0;
		o_scl_oe = 1'b0;
		o_miso = 1'b0;
		ptr = 8'h00;
		forever begin
			@(negedge i_sda iff i_scl);
			i2c_frame();
		end
	end
	// spi receive: command byte, then data bytes to ascending registers
	always @(posedge i_sclk) begin
		if (!i_cs_n) begin
			ssh = {ssh[6:0], i_mosi};
			scnt++;
			if (scnt == 8) begin
				srd = ssh[7];
				ptr = {1'b0, ssh[6:0]};
			end else if (scnt % 8 == 0) begin
				if (srd == SPI_DIR_WRITE) regs[ptr] = ssh;
				ptr++;
			end
		end
	end
	// spi drive on falling clock; an undriven line shows the inverse of its last level
	always @(negedge i_sclk or posedge i_cs_n) begin
		if (!i_cs_n && srd == SPI_DIR_READ && scnt >= 8)
			o_miso = regs[ptr][7 - scnt % 8];
		else
			o_miso = ~o_miso;
	end
	always @(negedge i_cs_n) scnt = 0;
endmodule

// ===== verification/testbench.sv
/*
 Self-checking bench for the host serial controller against the slave model.
 Assumes the design package and the slave model are compiled first.
*/
`timescale 1ns/1ns
module testbench
	import gyro_link_pkg::*;
;
	logic i_core_clk, i_rst, i_cmd_valid, i_cmd_spi, i_cmd_read, i_address_select_pin;
	logic i_wr_valid, i_rd_ready, o_cmd_ready, o_wr_ready, o_rd_valid, o_busy, o_done, o_ack_err;
	logic [7:0] i_cmd_reg, i_cmd_len, i_wr_data, o_rd_data;
	logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_sclk, o_cs_n, o_mosi, i_miso;
	logic dev_scl_oe, dev_sda_oe, dev_sel, dev_slow, scl_w, sda_w;
	int failures = 0, total_checks = 0, cycles = 0, starts = 0, stops = 0;
	int sclk_rises = 0, cs_falls = 0;
	longint sclk_last = 0, sclk_gap = 0;
	logic [7:0] wq[$], rq[$];
	// open-drain wires with pull-ups
	assign scl_w = !(o_scl_oe || dev_scl_oe);
	assign sda_w = !(o_sda_oe || dev_sda_oe);
	gyro_host_ctrl u_gyro_host_ctrl (.i_scl(scl_w), .i_sda(sda_w), .*);
	gyro_slave_model u_gyro_slave_model (.i_sel(dev_sel), .i_slow(dev_slow), .i_scl(scl_w),
		.i_sda(sda_w), .o_scl_oe(dev_scl_oe), .o_sda_oe(dev_sda_oe), .i_sclk(o_sclk),
		.i_cs_n(o_cs_n), .i_mosi(o_mosi), .o_miso(i_miso));
	// wire watchers for framing counts
	always @(negedge sda_w) if (scl_w) starts++;
	always @(posedge sda_w) if (scl_w) stops++;
	always @(posedge o_sclk) if (!o_cs_n) sclk_rises++;
	// spacing of the last two serial clock rises
	always @(posedge o_sclk) begin
		sclk_gap = $time - sclk_last;
		sclk_last = $time;
	end
	always @(negedge o_cs_n) cs_falls++;
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// hang guard
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			complete_run();
		end
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one command: feed the write queue, gather read bytes until done
	task automatic run_cmd(input logic spi, rd, sel, stall, input logic [7:0] rg, ln);
		rq = {};
		@(posedge i_core_clk);
		i_cmd_valid <= 1'b1;
		{i_cmd_spi, i_cmd_read, i_address_select_pin, i_cmd_reg, i_cmd_len} <= {spi, rd, sel, rg, ln};
		i_wr_valid <= wq.size() > 0;
		if (wq.size() > 0) i_wr_data <= wq[0];
		@(posedge i_core_clk);
		while (o_cmd_ready !== 1'b1) @(posedge i_core_clk);
		i_cmd_valid <= 1'b0;
		@(posedge i_core_clk);
		check("busy", 1, o_busy);
		check("cmd_ready", 0, o_cmd_ready);
		for (int n = 0; n < 60000 && o_done !== 1'b1; n++) begin
			i_rd_ready <= !stall || n > 20000;
			@(posedge i_core_clk);
			if (i_wr_valid && o_wr_ready === 1'b1) begin
				void'(wq.pop_front());
				i_wr_valid <= wq.size() > 0;
				if (wq.size() > 0) i_wr_data <= wq[0];
			end
			if (i_rd_ready && o_rd_valid === 1'b1) rq.push_back(o_rd_data);
		end
		i_wr_valid <= 1'b0;
		if (o_done !== 1'b1) begin
			failures++;
			$display("FAIL done expected 1 seen %b", o_done);
			complete_run();
		end
	endtask
	// i2c burst write lands in consecutive registers
	task automatic t_i2c_write();
		wq = {8'h11, 8'h22, 8'h33};
		run_cmd(0, 0, 0, 0, 8'h10, 8'h02);
		for (int k = 0; k < 3; k++) check("reg", 8'(17 * (k + 1)), u_gyro_slave_model.regs[16 + k]);
		check("ack_err", 0, o_ack_err);
		$display("test i2c_write ended");
	endtask
	// spi burst read returns them in register order
	task automatic t_spi_read();
		sclk_rises = 0;
		run_cmd(1, 1, 0, 0, 8'h10, 8'h02);
		check("count", 3, 8'(rq.size()));
		for (int k = 0; k < 3; k++) check("rd", 8'(17 * (k + 1)), rq[k]);
		check("sclk", 32, 8'(sclk_rises));
		$display("test spi_read ended");
	endtask
	// spi single write at the top of the seven-bit range
	task automatic t_spi_write();
		wq = {8'hA5};
		sclk_rises = 0;
		run_cmd(1, 0, 0, 0, 8'h7F, 8'h00);
		check("reg", 8'hA5, u_gyro_slave_model.regs[127]);
		check("sclk", 16, 8'(sclk_rises));
		check("sclk_period_ok", 1, 8'(sclk_gap >= SPI_SCLK_PERIOD_NS));
		$display("test spi_write ended");
	endtask
	// i2c read via repeated start, slow slave, reader stalled for 20000 cycles so the buffer fills
	task automatic t_i2c_read();
		dev_sel <= 1'b1;
		dev_slow <= 1'b1;
		starts = 0;
		stops = 0;
		run_cmd(0, 1, 1, 1, 8'h7E, 8'h02);
		check("count", 3, 8'(rq.size()));
		check("rd0", 8'h81, rq[0]);
		check("rd1", 8'hA5, rq[1]);
		check("rd2", 8'h7F, rq[2]);
		check("starts", 2, 8'(starts));
		check("stops", 1, 8'(stops));
		dev_slow <= 1'b0;
		$display("test i2c_read ended");
	endtask
	// wrong select level: slave stays silent, host flags it, spi untouched
	task automatic t_i2c_nack();
		cs_falls = 0;
		wq = {8'h5A};
		run_cmd(0, 0, 0, 0, 8'h40, 8'h00);
		check("ack_err", 1, o_ack_err);
		check("reg", 8'hBF, u_gyro_slave_model.regs[64]);
		check("cs_falls", 0, 8'(cs_falls));
		check("scl_out", 0, o_scl_out);
		check("sda_out", 0, o_sda_out);
		$display("test i2c_nack ended");
	endtask
	initial begin
		{i_cmd_valid, i_cmd_spi, i_cmd_read, i_address_select_pin, i_wr_valid, i_rd_ready} = '0;
		{i_cmd_reg, i_cmd_len, i_wr_data, dev_sel, dev_slow} = '0;
		i_rst = 1'b1;
		repeat (16) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		t_i2c_write();
		t_spi_read();
		t_spi_write();
		t_i2c_read();
		t_i2c_nack();
		complete_run();
	end
endmodule
